// ### fpps_pkg.sv
// Package with offsets, field positions, opcodes and types of the power and program status register.
`default_nettype none
package fpps_pkg;
  // APB address width and the register's byte offset.
  localparam int          FPPS_AW      = 12;
  localparam logic [11:0] FPPS_REG_OFS = 12'h000;
  // Field positions inside the 8-bit register.
  localparam int          PDL_BIT      = 7;
  localparam int          SEQ_BIT      = 6;
  localparam int          PERR_BIT     = 5;
  localparam int          EERR_BIT     = 4;
  localparam int          XIP_BIT      = 3;
  localparam int          BWS_LSB      = 0;
  localparam int          BWS_W        = 3;
  // Register value after reset.
  localparam logic [7:0]  REG_RST      = 8'h01;
  // Opcodes seen on the serial link.
  localparam logic [7:0]  OP_PD_SEL    = 8'hB9;
  localparam logic [7:0]  OP_ULTRA     = 8'h79;
  localparam logic [7:0]  OP_WAKE      = 8'hAB;
  localparam logic [7:0]  OP_WRAP      = 8'h77;
  localparam logic [7:0]  OP_QRD_A     = 8'hE7;
  localparam logic [7:0]  OP_QRD_B     = 8'hEB;
  // Position of the wrap control bits in the byte after the wrap opcode.
  localparam int          WRAP_LSB     = 4;
  // Link bit counts: last bit of the command byte and of the wrap byte.
  localparam logic [3:0]  CMD_LAST     = 4'h7;
  localparam logic [3:0]  WRAP_LAST    = 4'hF;
  // Power state of the device.
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_DEEP, PWR_ULTRA} fpps_pwr_e;
endpackage : fpps_pkg
`default_nettype wire

// ### fpps_status_reg.sv
// Power-down select, sequential program, failure, XiP and burst-wrap status register with its link decoder.
//
// Operation
// [RULE_01] Select bit 0: generic power-down opcode enters ultra-deep sleep, buffer lost.
// [RULE_02] Select bit 1: generic power-down opcode enters deep power-down, buffer kept.
// [RULE_03] Only the wake opcode leaves either power-down level.
// [RULE_04] Chip select toggling without a full wake opcode keeps power-down.
// [RULE_05] Bit 6 reads sequential programming state; cleared by reset.
// [RULE_06] In sequential mode later transfers skip the address; device tracks it.
// [RULE_07] Program error sets the read-only flag at bit 5.
// [RULE_08] Erase error sets the read-only flag at bit 4.
// [RULE_09] Writable bit 3, reset 0, enables continuous quad read mode.
// [RULE_10] With XiP on, first quad read has opcode, later ones omit it.
// [RULE_11] No command-less access unless XiP enable and quad enable are both set.
// [RULE_12] Bits 2:0 mirror wrap control bits of the last wrap opcode, reset 001.
// [RULE_13] Host writes to read-only fields are ignored.
`default_nettype none
module fpps_status_reg (
  input  wire logic                        mclk,           // System clock.
  input  wire logic                        rstn,           // Asynchronous reset, active low.
  input  wire logic [fpps_pkg::FPPS_AW-1:0] paddr,         // APB address.
  input  wire logic                        psel,           // APB select.
  input  wire logic                        penable,        // APB enable.
  input  wire logic                        pwrite,         // APB direction.
  input  wire logic [31:0]                 pwdata,         // APB write data.
  input  wire logic [3:0]                  pstrb,          // APB byte strobes.
  output logic      [31:0]                 prdata,         // APB read data.
  output logic                             pready,         // APB ready.
  output logic                             pslverr,        // APB error on unmapped address.
  input  wire logic                        quad_io_enable, // Quad enable bit held elsewhere.
  input  wire logic                        seq_mode_enter, // Core enters sequential programming.
  input  wire logic                        seq_mode_exit,  // Core leaves sequential programming.
  input  wire logic                        dev_reset,      // Device software reset pulse.
  input  wire logic                        prog_fail_evt,  // Program operation failed.
  input  wire logic                        erase_fail_evt, // Erase operation failed.
  output logic                             pd_deep,        // Deep power-down, buffer kept.
  output logic                             pd_ultra,       // Ultra-deep sleep, buffer lost.
  output logic                             sram_clear,     // Pulse: drop buffer contents.
  input  wire logic                        sclk,           // Link clock from the host.
  input  wire logic                        cs_n,           // Link chip select, active low.
  input  wire logic                        si,             // Link serial input.
  output logic                             link_addr_skip, // Frame reuses the tracked address.
  output logic                             link_cmdless    // Frame carries no opcode.
);

  // ---------------- Link side, clocked by sclk ----------------

  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] cmd_q;
  logic       cmd_tgl_q;
  logic [2:0] wrap_q;
  logic       wrap_tgl_q;
  logic       cont_q;
  logic [2:0] ctl_s1_q;
  logic [2:0] ctl_s2_q;
  logic       cmdless_q;
  logic       addr_skip_q;
  logic       wrap_seen_q;
  logic       seq_q;
  logic       xip_q;

  // The frame logic is cleared whenever chip select is high.
  wire       frm_rst_n = rstn & ~cs_n;
  wire [7:0] sh_nx     = {sh_q[6:0], si};
  wire       seq_s     = ctl_s2_q[2];
  wire       xip_ok    = ctl_s2_q[1] & ctl_s2_q[0];
  wire       cmd_end   = (cnt_q == fpps_pkg::CMD_LAST) & ~cmdless_q;
  wire       wrap_end  = (cnt_q == fpps_pkg::WRAP_LAST) & ~cmdless_q & (cmd_q == fpps_pkg::OP_WRAP) & ~wrap_seen_q;
  wire       is_qrd    = (sh_nx == fpps_pkg::OP_QRD_A) | (sh_nx == fpps_pkg::OP_QRD_B);

  // Mode levels from the system side pass two flip-flops before use.
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      ctl_s1_q <= 3'h0;
      ctl_s2_q <= 3'h0;
    end else begin
      ctl_s1_q <= {seq_q, xip_q, quad_io_enable};
      ctl_s2_q <= ctl_s1_q;
    end
  end

  // Bit counter and shifter, restarted by every frame.
  always_ff @(posedge sclk or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      cnt_q <= 4'h0;
      sh_q  <= 8'h00;
    end else begin
      sh_q  <= sh_nx;
      cnt_q <= (cnt_q == fpps_pkg::WRAP_LAST) ? cnt_q : cnt_q + 4'h1;
    end
  end

  // Frame attributes fixed at the first bit and at the opcode.
  always_ff @(posedge sclk or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      cmdless_q   <= 1'b0;
      addr_skip_q <= 1'b0;
      wrap_seen_q <= 1'b0;
    end else begin
      if (cnt_q == 4'h0) begin
        cmdless_q <= cont_q & xip_ok; // RULE_10 RULE_11
      end
      // The counter saturates, so a long frame must not take the wrap byte twice.
      if (wrap_end) begin
        wrap_seen_q <= 1'b1;
      end
      if (cmd_end) begin
        addr_skip_q <= seq_s; // RULE_06
      end
    end
  end

  // Opcode capture and continuous read state, kept across frames.
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      cmd_q     <= 8'h00;
      cmd_tgl_q <= 1'b0;
      cont_q    <= 1'b0;
    end else begin
      if (cmd_end) begin
        cmd_q     <= sh_nx;
        cmd_tgl_q <= ~cmd_tgl_q;
      end
      if (!xip_ok) begin
        cont_q <= 1'b0; // RULE_11
      end else if (cmd_end && is_qrd) begin
        cont_q <= 1'b1; // RULE_10
      end
    end
  end

  // Wrap control bits taken from the byte after the wrap opcode.
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      wrap_q     <= fpps_pkg::REG_RST[fpps_pkg::BWS_LSB +: fpps_pkg::BWS_W];
      wrap_tgl_q <= 1'b0;
    end else if (wrap_end) begin
      wrap_q     <= sh_nx[fpps_pkg::WRAP_LSB +: fpps_pkg::BWS_W]; // RULE_12
      wrap_tgl_q <= ~wrap_tgl_q;
    end
  end

  assign link_cmdless   = cmdless_q;
  assign link_addr_skip = addr_skip_q;

  // ---------------- System side, clocked by mclk ----------------

  logic [1:0]              tg_s1_q;
  logic [1:0]              tg_s2_q;
  logic [1:0]              tg_s3_q;
  fpps_pkg::fpps_pwr_e     pwr_q;
  fpps_pkg::fpps_pwr_e     pwr_d;
  logic                    clr_q;
  logic                    pdl_q;
  logic                    perr_q;
  logic                    eerr_q;
  logic [2:0]              bws_q;
  logic [31:0]             rdata_q;

  // Link toggles cross by two flip-flops; a third finds the change.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tg_s1_q <= 2'h0;
      tg_s2_q <= 2'h0;
      tg_s3_q <= 2'h0;
    end else begin
      tg_s1_q <= {wrap_tgl_q, cmd_tgl_q};
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
    end
  end

  // Opcode and wrap data stay still long after their toggle moves.
  wire cmd_evt   = tg_s2_q[0] ^ tg_s3_q[0];
  wire wrap_evt  = tg_s2_q[1] ^ tg_s3_q[1];
  wire op_pd     = cmd_evt & (cmd_q == fpps_pkg::OP_PD_SEL);
  wire op_ultra  = cmd_evt & (cmd_q == fpps_pkg::OP_ULTRA);
  wire op_wake   = cmd_evt & (cmd_q == fpps_pkg::OP_WAKE);

  // Power state: only a complete wake opcode leaves power-down.
  always_comb begin
    pwr_d = pwr_q;
    unique case (pwr_q)
      fpps_pkg::PWR_ACTIVE: begin
        if (op_ultra || (op_pd && !pdl_q)) begin
          pwr_d = fpps_pkg::PWR_ULTRA; // RULE_01
        end else if (op_pd) begin
          pwr_d = fpps_pkg::PWR_DEEP; // RULE_02
        end
      end
      fpps_pkg::PWR_DEEP, fpps_pkg::PWR_ULTRA: begin
        if (op_wake) begin
          pwr_d = fpps_pkg::PWR_ACTIVE; // RULE_03 RULE_04
        end
      end
    endcase
  end

  // State register and the buffer drop pulse on entering ultra-deep sleep.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pwr_q <= fpps_pkg::PWR_ACTIVE;
      clr_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      clr_q <= (pwr_d == fpps_pkg::PWR_ULTRA) && (pwr_q != fpps_pkg::PWR_ULTRA); // RULE_01
    end
  end

  assign pd_deep    = (pwr_q == fpps_pkg::PWR_DEEP);
  assign pd_ultra   = (pwr_q == fpps_pkg::PWR_ULTRA);
  assign sram_clear = clr_q;

  // APB decode: one word, always ready, error on any other address.
  wire       hit    = (paddr == fpps_pkg::FPPS_REG_OFS);
  wire       acc    = psel & penable;
  wire       reg_wr = acc & pwrite & hit & pstrb[0];
  wire [7:0] reg_val = {pdl_q, seq_q, perr_q, eerr_q, xip_q, bws_q};

  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata  = rdata_q;

  // Writable bits: power-down level select and XiP enable only.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pdl_q <= fpps_pkg::REG_RST[fpps_pkg::PDL_BIT];
      xip_q <= fpps_pkg::REG_RST[fpps_pkg::XIP_BIT];
    end else if (reg_wr) begin
      pdl_q <= pwdata[fpps_pkg::PDL_BIT];
      xip_q <= pwdata[fpps_pkg::XIP_BIT]; // RULE_09
    end
  end

  // Hardware-owned bits; host writes never reach them, and a set beats a clear.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      seq_q  <= fpps_pkg::REG_RST[fpps_pkg::SEQ_BIT];
      perr_q <= fpps_pkg::REG_RST[fpps_pkg::PERR_BIT];
      eerr_q <= fpps_pkg::REG_RST[fpps_pkg::EERR_BIT];
      bws_q  <= fpps_pkg::REG_RST[fpps_pkg::BWS_LSB +: fpps_pkg::BWS_W];
    end else begin
      seq_q  <= seq_mode_enter | (seq_q & ~seq_mode_exit & ~dev_reset); // RULE_05 RULE_13
      perr_q <= prog_fail_evt | (perr_q & ~dev_reset); // RULE_07 RULE_13
      eerr_q <= erase_fail_evt | (eerr_q & ~dev_reset); // RULE_08 RULE_13
      if (wrap_evt) begin
        bws_q <= wrap_q; // RULE_12
      end
    end
  end

  // Read data sampled in the setup phase; zero for unmapped or write.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      rdata_q <= (hit && !pwrite) ? {24'h00_0000, reg_val} : 32'h0000_0000;
    end
  end

  // ---------------- Checks ----------------

  // An opcode event followed one cycle later by the state it selects.
  sequence s_pd_req;
    op_pd && (pwr_q == fpps_pkg::PWR_ACTIVE);
  endsequence

  property p_pd_level(logic sel, fpps_pkg::fpps_pwr_e st);
    @(posedge mclk) disable iff (!rstn)
      s_pd_req and (pdl_q == sel) |=> (pwr_q == st);
  endproperty

  AST_PD_ULTRA: assert property (p_pd_level(1'b0, fpps_pkg::PWR_ULTRA)) // RULE_01
    else $error("Power-down with select 0 did not enter ultra-deep sleep.");

  AST_PD_DEEP: assert property (p_pd_level(1'b1, fpps_pkg::PWR_DEEP)) // RULE_02
    else $error("Power-down with select 1 did not enter deep power-down.");

  AST_ULTRA_CLEAR: assert property (@(posedge mclk) disable iff (!rstn) // RULE_01
      $rose(pd_ultra) |-> sram_clear)
    else $error("Entering ultra-deep sleep did not drop the buffer.");

  AST_WAKE: assert property (@(posedge mclk) disable iff (!rstn) // RULE_03
      (pwr_q != fpps_pkg::PWR_ACTIVE) && op_wake |=> (pwr_q == fpps_pkg::PWR_ACTIVE))
    else $error("Wake opcode did not leave power-down.");

  AST_STAY_DOWN: assert property (@(posedge mclk) disable iff (!rstn) // RULE_04
      (pwr_q != fpps_pkg::PWR_ACTIVE) && !op_wake |=> $stable(pwr_q))
    else $error("Power-down left without a wake opcode.");

  AST_SEQ: assert property (@(posedge mclk) disable iff (!rstn) // RULE_05
      seq_mode_enter ##1 (!seq_mode_exit && !dev_reset) |=> seq_q)
    else $error("Sequential programming flag lost.");

  AST_PERR: assert property (@(posedge mclk) disable iff (!rstn) // RULE_07
      prog_fail_evt |=> perr_q ##1 ($past(dev_reset) || perr_q))
    else $error("Program failure flag not held.");

  AST_EERR: assert property (@(posedge mclk) disable iff (!rstn) // RULE_08
      erase_fail_evt |=> eerr_q)
    else $error("Erase failure flag not set.");

  AST_XIP_WR: assert property (@(posedge mclk) disable iff (!rstn) // RULE_09
      reg_wr |=> (xip_q == $past(pwdata[fpps_pkg::XIP_BIT])) && (pdl_q == $past(pwdata[fpps_pkg::PDL_BIT])))
    else $error("Writable bits did not take the written value.");

  AST_WRAP: assert property (@(posedge mclk) disable iff (!rstn) // RULE_12
      wrap_evt |=> (bws_q == wrap_q))
    else $error("Burst wrap field did not follow the wrap opcode.");

  AST_RO_HOLD: assert property (@(posedge mclk) disable iff (!rstn) // RULE_13
      reg_wr && !wrap_evt && !seq_mode_enter && !seq_mode_exit && !dev_reset
        && !prog_fail_evt && !erase_fail_evt |=> $stable({reg_val[6:4], reg_val[2:0]}))
    else $error("Host write changed a read-only field.");

  AST_CMDLESS: assert property (@(posedge sclk) disable iff (!rstn) // RULE_11
      !xip_ok |=> !cont_q && (($past(cnt_q) != 4'h0) || !cmdless_q))
    else $error("Command-less state kept without XiP and quad enable.");

endmodule : fpps_status_reg
`default_nettype wire

// ### fpps_placeholder_none.sv
// Intentionally empty compile unit kept minimal.
`default_nettype none
`default_nettype wire

// ### fpps_spi_host.sv
// Behavioural SPI host that clocks opcode frames into the status register block.
`default_nettype none
module fpps_spi_host (
  output logic sclk, // Link clock, still between frames.
  output logic cs_n, // Chip select, active low.
  output logic si    // Serial data, MSB first.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle levels of the link before the first frame.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end
  // Sends the top n bits of d in one frame, then idles long enough for the system domain.
  task automatic frame(input logic [15:0] d, input int n);
    #37;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = d[15-i];
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    si = ~si; // A released line must not keep showing the last bit.
    #760;
  endtask : frame
endmodule : fpps_spi_host
`default_nettype wire

// ### flash_power_program_status_reg_bench.sv
// Self-checking bench of the power and program status register block.
`default_nettype none
module flash_power_program_status_reg_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0] ev; logic [11:0] a; logic [7:0] d; logic [3:0] s; logic [7:0] x; logic e;
  } fpps_row_s;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'h0;
  logic        qe = 1'b0;
  logic [4:0]  ev = 5'h00;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, pd_deep, pd_ultra, sram_clear, sclk, cs_n, si, skip, cmdless, er;
  logic        saw_cl = 1'b0;
  logic        saw_sk = 1'b0;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          n_clr = 0;
  int          nc;
  // Event bits: program fail, erase fail, sequential enter, device reset, sequential exit.
  fpps_row_s rows [10] = '{
    '{5'h00, 12'h000, 8'hFF, 4'hF, 8'h89, 1'b0}, '{5'h00, 12'h000, 8'h00, 4'hE, 8'h89, 1'b0},
    '{5'h00, 12'h004, 8'h00, 4'hF, 8'h00, 1'b1}, '{5'h00, 12'h000, 8'h08, 4'hF, 8'h09, 1'b0},
    '{5'h01, 12'h000, 8'h00, 4'hF, 8'h29, 1'b0}, '{5'h02, 12'h000, 8'h00, 4'hF, 8'h39, 1'b0},
    '{5'h04, 12'h000, 8'h00, 4'hF, 8'h79, 1'b0}, '{5'h00, 12'h000, 8'h00, 4'hF, 8'h71, 1'b0},
    '{5'h10, 12'h000, 8'h00, 4'hF, 8'h31, 1'b0}, '{5'h08, 12'h000, 8'h00, 4'hF, 8'h01, 1'b0}};
  logic [7:0] pdw [3] = '{8'h80, 8'h00, 8'h80};
  logic [7:0] pop [3] = '{fpps_pkg::OP_PD_SEL, fpps_pkg::OP_PD_SEL, fpps_pkg::OP_ULTRA};
  logic       pdeep [3] = '{1'b1, 1'b0, 1'b0};
  logic [2:0] wv [2] = '{3'b101, 3'b000};
  logic [7:0] xop [3] = '{fpps_pkg::OP_QRD_A, fpps_pkg::OP_QRD_B, fpps_pkg::OP_QRD_A};
  logic       xq [3] = '{1'b0, 1'b1, 1'b1};
  logic [4:0] sq [2] = '{5'h04, 5'h10};

  fpps_status_reg fpps_status_reg_i (
    .mclk(mclk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .quad_io_enable(qe), .seq_mode_enter(ev[2]), .seq_mode_exit(ev[4]), .dev_reset(ev[3]),
    .prog_fail_evt(ev[0]), .erase_fail_evt(ev[1]), .pd_deep(pd_deep), .pd_ultra(pd_ultra),
    .sram_clear(sram_clear), .sclk(sclk), .cs_n(cs_n), .si(si), .link_addr_skip(skip),
    .link_cmdless(cmdless));
  fpps_spi_host fpps_spi_host_i (.sclk(sclk), .cs_n(cs_n), .si(si));

  // System clock and monitors of the link flags and buffer clear pulses.
  always #50 mclk = ~mclk;
  always @(negedge sclk) begin
    if (!cs_n && cmdless === 1'b1) saw_cl = 1'b1;
    if (!cs_n && skip === 1'b1) saw_sk = 1'b1;
  end
  always @(negedge mclk) begin
    if (sram_clear === 1'b1) n_clr++;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  // Compares a seen value against the expected one.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer: setup, access until pready, then release.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_errors++;
      wrap_up();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // Waits a bounded time for the power-down state to become want.
  task automatic wait_pd(input logic want);
    for (int k = 0; k < 40; k++) begin
      @(negedge mclk);
      if ((pd_deep | pd_ultra) === want) return;
    end
    n_errors++;
    wrap_up();
  endtask : wait_pd

  // Main sequence: reset, table of register cases, then link scenarios.
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0000_0000, 4'hF, rd, er);
    chk(rd, 32'h0000_0001);
    chk(32'({pd_deep, pd_ultra, sram_clear, cmdless, skip}), 32'h0000_0000);
    foreach (rows[i]) begin
      if (rows[i].ev != 5'h00) begin
        @(posedge mclk) ev <= rows[i].ev;
        @(posedge mclk) ev <= 5'h00;
      end else begin
        apb(1'b1, rows[i].a, {24'h00_0000, rows[i].d}, rows[i].s, rd, er);
        chk(32'(er), 32'(rows[i].e));
      end
      apb(1'b0, rows[i].a, 32'h0000_0000, 4'hF, rd, er);
      chk(rd, {24'h00_0000, rows[i].x});
      chk(32'(er), 32'(rows[i].e));
    end
    foreach (pdw[i]) begin
      apb(1'b1, 12'h000, {24'h00_0000, pdw[i]}, 4'hF, rd, er);
      nc = n_clr;
      fpps_spi_host_i.frame({pop[i], 8'h00}, 8);
      wait_pd(1'b1);
      chk(32'(pd_deep), 32'(pdeep[i]));
      chk(32'(pd_ultra), 32'(!pdeep[i]));
      fpps_spi_host_i.frame({fpps_pkg::OP_WAKE, 8'h00}, 5);
      fpps_spi_host_i.frame(16'h0000, 0);
      repeat (10) @(posedge mclk);
      chk(32'(pd_deep | pd_ultra), 32'h0000_0001);
      chk(32'(n_clr - nc), 32'(!pdeep[i]));
      fpps_spi_host_i.frame({fpps_pkg::OP_WAKE, 8'h00}, 8);
      wait_pd(1'b0);
      chk(32'(pd_deep | pd_ultra), 32'h0000_0000);
    end
    foreach (wv[i]) begin
      fpps_spi_host_i.frame({fpps_pkg::OP_WRAP, 1'b0, wv[i], 4'h0}, 16);
      repeat (10) @(posedge mclk);
      apb(1'b0, 12'h000, 32'h0000_0000, 4'hF, rd, er);
      chk(rd, {24'h00_0000, 5'h10, wv[i]});
    end
    apb(1'b1, 12'h000, 32'h0000_0008, 4'hF, rd, er);
    foreach (xop[i]) begin
      @(posedge mclk) qe <= 1'b0;
      fpps_spi_host_i.frame(16'h0000, 8);
      @(posedge mclk) qe <= xq[i];
      fpps_spi_host_i.frame({xop[i], 8'h00}, 8);
      saw_cl = 1'b0;
      fpps_spi_host_i.frame(16'h0000, 8);
      chk(32'(saw_cl), 32'(xq[i]));
    end
    @(posedge mclk) qe <= 1'b0;
    fpps_spi_host_i.frame(16'h0000, 8);
    foreach (sq[i]) begin
      @(posedge mclk) ev <= sq[i];
      @(posedge mclk) ev <= 5'h00;
      saw_sk = 1'b0;
      fpps_spi_host_i.frame(16'h0200, 16);
      chk(32'(saw_sk), 32'(sq[i] == 5'h04));
    end
    wrap_up();
  end
endmodule : flash_power_program_status_reg_bench
`default_nettype wire
